//--- wake_ctl_defines.svh
/*
  Timing counts, register offsets, field positions and reset values of the
  sleep and wake regulator control block.
  Assumes the includer runs on a 25 MHz clock and decodes APB byte addresses.
*/
`ifndef WAKE_CTL_DEFINES_SVH
`define WAKE_CTL_DEFINES_SVH

// ----------------------------------------------------------------------------
// Clock and oscillator
// ----------------------------------------------------------------------------
// System clock frequency in kHz.
`define WCTL_CLK_KHZ 25000
// Internal logic oscillator frequency in kHz.
`define WCTL_OSC_KHZ 500
// System clock cycles per oscillator tick.
`define WCTL_OSC_DIV (`WCTL_CLK_KHZ / `WCTL_OSC_KHZ)

// ----------------------------------------------------------------------------
// Hold delay of the regulator enable, in milliseconds and oscillator ticks
// ----------------------------------------------------------------------------
// Shortest allowed falling delay in ms.
`define WCTL_HOLD_MIN_MS 300
// Longest allowed falling delay in ms.
`define WCTL_HOLD_MAX_MS 1000
// Default hold delay in ms, placed between the bounds.
`define WCTL_HOLD_DEF_MS 500
// Default hold delay in oscillator ticks.
`define WCTL_HOLD_DEF_TICKS (`WCTL_HOLD_DEF_MS * `WCTL_OSC_KHZ)
// Least legal limit in ticks; smaller writes are raised to it.
`define WCTL_HOLD_MIN_TICKS (`WCTL_HOLD_MIN_MS * `WCTL_OSC_KHZ)
// Largest legal limit in ticks; larger writes are cut to it.
`define WCTL_HOLD_MAX_TICKS (`WCTL_HOLD_MAX_MS * `WCTL_OSC_KHZ)

// ----------------------------------------------------------------------------
// Transmit driver hold and wake filter, in oscillator ticks
// ----------------------------------------------------------------------------
// Ticks the driver stays enabled after a passive level.
`define WCTL_TX_HOLD_TICKS 16
// Ticks the wake level must stand before it is believed.
`define WCTL_WAKE_FILT_TICKS 8

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define WCTL_OFS_STATUS 12'h000
`define WCTL_OFS_IRQ 12'h004
`define WCTL_OFS_MASK 12'h008
`define WCTL_OFS_HOLD 12'h00C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
// Status: mode in bits 1:0, enable out, wake, undervoltage, ground loss.
`define WCTL_ST_REG_EN 2
`define WCTL_ST_WAKE 3
`define WCTL_ST_UV 4
`define WCTL_ST_GND 5
// Interrupt bits: wake exit, enable fell, undervoltage, ground loss.
`define WCTL_IRQ_WAKE 0
`define WCTL_IRQ_FALL 1
`define WCTL_IRQ_UV 2
`define WCTL_IRQ_GND 3
`define WCTL_IRQ_W 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define WCTL_RST_MASK 4'h0

`endif

//--- wake_ctl_pkg.sv
/*
  Types of the sleep and wake regulator control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package wake_ctl_pkg;

  // Operating mode decoded from the two mode-select pins {lo, hi}.
  typedef enum logic [1:0]
  {
    mode_sleep = 2'b00,
    mode_hv_wake = 2'b01,
    mode_high_speed = 2'b10,
    mode_normal = 2'b11
  } mode_t;

  // Power state of the device, one-hot.
  typedef enum logic [2:0]
  {
    pw_sleep = 3'b001,
    pw_hold = 3'b010,
    pw_awake = 3'b100
  } power_state_t;

endpackage

//--- tick_if.sv
/*
  Interface carrying the oscillator tick between the divider and its users.
  Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none

interface tick_if;
  // One-cycle pulse at the oscillator rate.
  logic tick;
  modport source (output tick);
  modport sink (input tick);
endinterface // tick_if

`default_nettype wire

//--- osc_tick.sv
/*
  Divider standing in for the internal logic oscillator.
  Assumes a free-running clock and the divide ratio from the defines header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wake_ctl_defines.svh"

module osc_tick
#(
  parameter int unsigned DIV = `WCTL_OSC_DIV
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Tick out
  tick_if.source tk
);

  // Cycle counter within one oscillator period.
  logic [$clog2(DIV)-1:0] cnt_q;

  // --------------------------------------------------------------------------
  // Divider
  // --------------------------------------------------------------------------
  // Counts up through the period and raises the tick for one cycle at its end.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      tk.tick <= 1'b0;
    end
    else if (cnt_q == $clog2(DIV)'(DIV - 1))
    begin
      cnt_q <= '0;
      tk.tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      tk.tick <= 1'b0;
    end
  end

endmodule // osc_tick

`default_nettype wire

//--- pin_sync.sv
/*
  Three-stage synchroniser for a group of pins; a change is taken once the
  second and third stages agree.
  Assumes asynchronous inputs and a single destination clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync
#(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins and settled values
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);

  // Stages; the first is only read by the second.
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // --------------------------------------------------------------------------
  // Shift and agree
  // --------------------------------------------------------------------------
  // Each bit follows only when two later stages match, hiding one-cycle
  // metastable settling from the block.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      level <= INIT;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++)
      begin
        if (s2_q[i] == s3_q[i])
          level[i] <= s3_q[i];
      end
    end
  end

endmodule // pin_sync

`default_nettype wire

//--- sleep_wake_ctl.sv
/*
  Sleep and wake control of a single-wire bus transceiver: mode decode,
  regulator enable with hold timer, transmit driver hold, wake filter,
  undervoltage gating, load switch, and an APB register file with interrupt.
  Assumes pins arrive asynchronously and APB runs on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wake_ctl_defines.svh"

module sleep_wake_ctl
#(
  parameter int unsigned HOLD_TICKS = `WCTL_HOLD_DEF_TICKS,
  parameter int unsigned TX_HOLD_TICKS = `WCTL_TX_HOLD_TICKS,
  parameter int unsigned FILT_TICKS = `WCTL_WAKE_FILT_TICKS
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host pins
  input wire logic mode_select_lo,
  input wire logic mode_select_hi,
  input wire logic txd,
  output logic rxd_low_oe,
  output logic regulator_enable_out,
  // Line side
  input wire logic bus_dominant,
  input wire logic high_voltage_wake,
  input wire logic under_voltage,
  input wire logic ground_lost,
  output logic line_driver_en,
  output logic line_driver_dominant,
  output logic line_driver_hv,
  output logic line_driver_shaped,
  output logic line_receiver_en,
  output logic load_switch_on,
  // Interrupt
  output logic irq
);

  // --------------------------------------------------------------------------
  // Pin synchronisation and oscillator
  // --------------------------------------------------------------------------
  // Settled pin levels; reset as undriven (sleep pins, recessive data).
  logic [6:0] pins_s;
  // Shared oscillator tick.
  tick_if tk ();

  pin_sync #(.W(7), .INIT(7'b000_0010)) u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .pin({ground_lost, under_voltage, high_voltage_wake, bus_dominant,
          mode_select_hi, txd, mode_select_lo}),
    .level(pins_s)
  );

  osc_tick u_osc
  (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk.source)
  );

  // Decoded names of the settled pins.
  wire logic mlo = pins_s[0];
  wire logic txd_s = pins_s[1];
  wire logic mhi = pins_s[2];
  wire logic dom_s = pins_s[3];
  wire logic hvw_s = pins_s[4];
  wire logic uv_s = pins_s[5];
  wire logic gnd_s = pins_s[6];

  // mode decode from the two select pins
  wake_ctl_pkg::mode_t mode;
  assign mode = wake_ctl_pkg::mode_t'({mlo, mhi});

  // --------------------------------------------------------------------------
  // Wake filter
  // --------------------------------------------------------------------------
  // The wake level must stand for a number of ticks; this stands in for the
  // analog de-glitch filter so a bus spike cannot wake the host.
  logic [$clog2(FILT_TICKS+1)-1:0] filt_q;
  logic wake_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filt_q <= '0;
      wake_q <= 1'b0;
    end
    else if (!hvw_s)
    begin
      filt_q <= '0;
      wake_q <= 1'b0;
    end
    else if (tk.tick && !wake_q)
    begin
      if (filt_q == $clog2(FILT_TICKS+1)'(FILT_TICKS - 1))
        wake_q <= 1'b1;
      filt_q <= filt_q + 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Hold timer and power state
  // --------------------------------------------------------------------------
  // Hold limit register, in ticks.
  logic [19:0] hold_lim_q;
  // Ticks since the wake level left.
  logic [19:0] hold_q;
  // Hold delay expired.
  logic hold_done;
  wake_ctl_pkg::power_state_t pw_q;
  // One-cycle events for the interrupt status register.
  logic ev_wake;
  logic ev_fall;

  assign hold_done = (hold_q >= hold_lim_q);

  // counter restarts on wake, stops at limit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_q <= '0;
    else if (wake_q)
      hold_q <= '0;
    else if (tk.tick && !hold_done)
      hold_q <= hold_q + 1'b1;
  end

  // Power state machine. Awake holds as long as the host keeps a non-sleep
  // mode; sleep pins only take effect once the hold delay has run out.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pw_q <= wake_ctl_pkg::pw_sleep;
      ev_wake <= 1'b0;
      ev_fall <= 1'b0;
    end
    else
    begin
      ev_wake <= 1'b0;
      ev_fall <= 1'b0;
      unique case (pw_q)
        wake_ctl_pkg::pw_sleep:
        begin
          if (wake_q)
          begin
            pw_q <= wake_ctl_pkg::pw_hold;
            ev_wake <= 1'b1;
          end
          else if (mode != wake_ctl_pkg::mode_sleep)
            pw_q <= wake_ctl_pkg::pw_awake;
        end
        wake_ctl_pkg::pw_hold:
        begin
          // expired delay and sleep pins end it
          if (hold_done && mode == wake_ctl_pkg::mode_sleep)
          begin
            pw_q <= wake_ctl_pkg::pw_sleep;
            ev_fall <= 1'b1;
          end
          else if (mode != wake_ctl_pkg::mode_sleep)
            pw_q <= wake_ctl_pkg::pw_awake;
        end
        wake_ctl_pkg::pw_awake:
        begin
          // Sleep pins return to the hold state before the drop; the hold count is not restarted.
          if (mode == wake_ctl_pkg::mode_sleep)
            pw_q <= wake_ctl_pkg::pw_hold;
        end
        default:
          pw_q <= wake_ctl_pkg::pw_sleep;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      regulator_enable_out <= 1'b0;
    else
      regulator_enable_out <= (pw_q != wake_ctl_pkg::pw_sleep);
  end

  // --------------------------------------------------------------------------
  // Transmit driver hold
  // --------------------------------------------------------------------------
  // Ticks left for which the driver stays on after a passive level.
  logic [$clog2(TX_HOLD_TICKS+1)-1:0] txh_q;

  // driver stays enabled after passive level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      txh_q <= '0;
    else if (!txd_s)
      txh_q <= $clog2(TX_HOLD_TICKS+1)'(TX_HOLD_TICKS);
    else if (tk.tick && txh_q != '0)
      txh_q <= txh_q - 1'b1;
  end

  // Line driver and receiver controls, all registered.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_driver_en <= 1'b0;
      line_driver_dominant <= 1'b0;
      line_driver_hv <= 1'b0;
      line_driver_shaped <= 1'b1;
      line_receiver_en <= 1'b0;
      load_switch_on <= 1'b1;
      rxd_low_oe <= 1'b0;
    end
    else
    begin
      line_driver_en <= !uv_s && (!txd_s || txh_q != '0);
      line_driver_dominant <= !uv_s && !txd_s;
      // wake voltage only in wake mode
      line_driver_hv <= (mode == wake_ctl_pkg::mode_hv_wake);
      line_driver_shaped <= (mode != wake_ctl_pkg::mode_high_speed);
      line_receiver_en <= !uv_s && (pw_q != wake_ctl_pkg::pw_sleep ||
                                    hvw_s);
      rxd_low_oe <= !uv_s && dom_s &&
                    (pw_q != wake_ctl_pkg::pw_sleep || hvw_s);
      load_switch_on <= !gnd_s;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status and mask
  // --------------------------------------------------------------------------
  logic [`WCTL_IRQ_W-1:0] ist_q;
  logic [`WCTL_IRQ_W-1:0] msk_q;
  logic [`WCTL_IRQ_W-1:0] ev;
  logic uv_d1_q;
  logic gnd_d1_q;
  // APB access phase strobes.
  logic acc;
  logic wr;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign ev = {gnd_s && !gnd_d1_q, uv_s && !uv_d1_q, ev_fall, ev_wake};

  // Edge memories for the level events.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      uv_d1_q <= 1'b0;
      gnd_d1_q <= 1'b0;
    end
    else
    begin
      uv_d1_q <= uv_s;
      gnd_d1_q <= gnd_s;
    end
  end

  // Sticky bits; a new event in the clearing cycle wins over the clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ist_q <= '0;
    else if (wr && paddr == `WCTL_OFS_IRQ)
      ist_q <= (ist_q & ~pwdata[`WCTL_IRQ_W-1:0]) | ev;
    else
      ist_q <= ist_q | ev;
  end

  // Mask and hold limit registers; written limits are kept inside the bounds, reset loads HOLD_TICKS as given.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      msk_q <= `WCTL_RST_MASK;
      hold_lim_q <= 20'(HOLD_TICKS);
    end
    else if (wr && paddr == `WCTL_OFS_MASK)
      msk_q <= pwdata[`WCTL_IRQ_W-1:0];
    // limit clamped to the legal range
    else if (wr && paddr == `WCTL_OFS_HOLD)
    begin
      if (pwdata[19:0] < 20'(`WCTL_HOLD_MIN_TICKS))
        hold_lim_q <= 20'(`WCTL_HOLD_MIN_TICKS);
      else if (pwdata[19:0] > 20'(`WCTL_HOLD_MAX_TICKS))
        hold_lim_q <= 20'(`WCTL_HOLD_MAX_TICKS);
      else
        hold_lim_q <= pwdata[19:0];
    end
  end

  // Level interrupt from unmasked sticky bits.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(ist_q & msk_q);
  end

  // --------------------------------------------------------------------------
  // APB read path
  // --------------------------------------------------------------------------
  // Zero wait states: pready rises in the first access cycle. Unmapped
  // addresses read zero and raise pslverr.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable)
      begin
        unique case (paddr)
          `WCTL_OFS_STATUS:
            prdata <= {26'h000_0000, gnd_s, uv_s, wake_q,
                       regulator_enable_out, mlo, mhi};
          `WCTL_OFS_IRQ:
            prdata <= {28'h000_0000, ist_q};
          `WCTL_OFS_MASK:
            prdata <= {28'h000_0000, msk_q};
          `WCTL_OFS_HOLD:
            prdata <= {12'h000, hold_lim_q};
          default:
            pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule // sleep_wake_ctl

`default_nettype wire

//--- sleep_wake_chk.sv
/*
  Port checker of the sleep and wake regulator control block.
  Assumes binding to sleep_wake_ctl, with pins held steady for many cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wake_ctl_defines.svh"

module sleep_wake_chk
#(
  parameter int unsigned HOLD_TICKS = `WCTL_HOLD_DEF_TICKS,
  parameter int unsigned TX_HOLD_TICKS = 16,
  parameter int unsigned FILT_TICKS = 8
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Host and line pins
  input wire logic mode_select_lo,
  input wire logic mode_select_hi,
  input wire logic txd,
  input wire logic rxd_low_oe,
  input wire logic regulator_enable_out,
  input wire logic high_voltage_wake,
  input wire logic under_voltage,
  input wire logic ground_lost,
  input wire logic line_driver_en,
  input wire logic line_driver_dominant,
  input wire logic line_driver_hv,
  input wire logic line_driver_shaped,
  input wire logic line_receiver_en,
  input wire logic load_switch_on
);
  // Clock cycles per oscillator tick.
  localparam int DIV = `WCTL_OSC_DIV;
  localparam int HOLD_LO = HOLD_TICKS < `WCTL_HOLD_MIN_TICKS ?
    HOLD_TICKS : `WCTL_HOLD_MIN_TICKS;
  // Run lengths of wake high, wake low and txd high.
  int hv_hi_q;
  int hv_lo_q;
  int tx_hi_q;

  // --------------------------------------------------------------------------
  // Run-length counters
  // --------------------------------------------------------------------------
  // The tick phase is unknown, so bounds below allow one tick of slack.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hv_hi_q <= 0;
      hv_lo_q <= 0;
      tx_hi_q <= 0;
    end
    else
    begin
      hv_hi_q <= high_voltage_wake ? hv_hi_q + 1 : 0;
      hv_lo_q <= high_voltage_wake ? 0 : hv_lo_q + 1;
      tx_hi_q <= txd ? tx_hi_q + 1 : 0;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_wake_filtered: assert property (
    $rose(regulator_enable_out) |-> hv_hi_q >= (FILT_TICKS - 1) * DIV)
    else $error("enable rose without a filtered wake");
  chk_hold_time: assert property (
    $fell(regulator_enable_out) |-> hv_lo_q >= (HOLD_LO - 1) * DIV)
    else $error("enable fell before the hold delay");
  chk_sleep_drop: assert property (
    $fell(regulator_enable_out) |-> !mode_select_lo && !mode_select_hi)
    else $error("enable fell outside sleep mode");
  chk_hv_on: assert property (
    (!mode_select_lo && mode_select_hi)[*8] |-> line_driver_hv)
    else $error("wake drive missing in wake mode");
  chk_hv_off: assert property (
    (mode_select_lo || !mode_select_hi)[*8] |-> !line_driver_hv)
    else $error("wake drive outside wake mode");
  chk_shape_mode: assert property (
    ($stable({mode_select_lo, mode_select_hi}))[*8] |->
      line_driver_shaped == !(mode_select_lo && !mode_select_hi))
    else $error("waveshaping wrong for mode");
  chk_uv_gate: assert property (
    under_voltage[*8] |-> !line_driver_en && !line_receiver_en && !rxd_low_oe)
    else $error("line live under undervoltage");
  chk_gnd_switch: assert property (
    ($stable(ground_lost))[*8] |-> load_switch_on == !ground_lost)
    else $error("load switch wrong for ground state");
  chk_dom_drive: assert property (
    (!txd && !under_voltage)[*8] |-> line_driver_en && line_driver_dominant)
    else $error("low transmit data not driven dominant");
  chk_tx_hold_min: assert property (
    $fell(line_driver_en) && !under_voltage |->
      tx_hi_q >= (TX_HOLD_TICKS - 1) * DIV)
    else $error("driver released before its hold");
  chk_tx_hold_max: assert property (
    line_driver_en |-> tx_hi_q <= (TX_HOLD_TICKS + 1) * DIV + 8)
    else $error("driver held past its hold");
  chk_apb_ready: assert property (
    psel && !penable |=> pready)
    else $error("no ready in first access cycle");

  cover property ($rose(regulator_enable_out));
  cover property ($fell(regulator_enable_out));
  cover property ($fell(load_switch_on));
endmodule // sleep_wake_chk

bind sleep_wake_ctl sleep_wake_chk #(.HOLD_TICKS(HOLD_TICKS),
  .TX_HOLD_TICKS(TX_HOLD_TICKS), .FILT_TICKS(FILT_TICKS)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .mode_select_lo(mode_select_lo),
  .mode_select_hi(mode_select_hi), .txd(txd), .rxd_low_oe(rxd_low_oe),
  .regulator_enable_out(regulator_enable_out),
  .high_voltage_wake(high_voltage_wake), .under_voltage(under_voltage),
  .ground_lost(ground_lost), .line_driver_en(line_driver_en),
  .line_driver_dominant(line_driver_dominant),
  .line_driver_hv(line_driver_hv), .line_driver_shaped(line_driver_shaped),
  .line_receiver_en(line_receiver_en), .load_switch_on(load_switch_on));

`default_nettype wire

//--- host_model.sv
/*
  Host microcontroller powered through the regulator enable.
  Assumes the bench sets the wanted mode and the boot time.
*/
`timescale 1ns/1ps
`default_nettype none

module host_model
(
  // Clock
  input wire logic pclk,
  // Supply and commands
  input wire logic regulator_enable_out,
  input wire logic [1:0] want_mode,
  input wire logic [7:0] boot_cycles,
  // Mode pins
  output logic mode_select_lo,
  output logic mode_select_hi
);
  // Cycles since the supply came up.
  int up_q = 0;

  // The host runs only while its regulator is enabled.
  always_ff @(posedge pclk)
  begin
    up_q <= regulator_enable_out ? up_q + 1 : 0;
  end

  // host mode pins
  // Unpowered, the pins sink to the pull-down level, which reads as sleep.
  always_comb
  begin
    if (up_q > int'(boot_cycles))
      {mode_select_lo, mode_select_hi} = want_mode;
    else
      {mode_select_lo, mode_select_hi} = 2'b00;
  end
endmodule // host_model

`default_nettype wire

//--- sleep_wake_regulator_control_tb_top.sv
/*
  Bench of sleep_wake_ctl: APB master, line pins and a host model.
  Assumes a short hold count to keep the run brief.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wake_ctl_defines.svh"

module sleep_wake_regulator_control_tb_top;
  // Short hold limit in ticks; cycles per tick.
  localparam int HOLD = 20;
  localparam int DIV = `WCTL_OSC_DIV;
  // Design pins.
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, txd = 1'b1, hvw = 1'b0, uv = 1'b0, gnd = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er, mlo, mhi, rxd_oe, reg_en, irq;
  logic drv_en, drv_dom, drv_hv, drv_shaped, rcv_en, load_on;
  // Host commands.
  logic [1:0] want = 2'b11;
  logic [7:0] boot = 8'h04;
  // Model state, tables and counters.
  int m_irq = 0, m_mask = 0, cnt = 0, cyc = 0;
  int bad_count = 0, total_checks = 0;
  int modes[$] = '{1, 2, 3};

  sleep_wake_ctl #(.HOLD_TICKS(HOLD)) u_sleep_wake_ctl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_select_lo(mlo),
    .mode_select_hi(mhi), .txd(txd), .rxd_low_oe(rxd_oe),
    .regulator_enable_out(reg_en), .bus_dominant(drv_dom),
    .high_voltage_wake(hvw), .under_voltage(uv), .ground_lost(gnd),
    .line_driver_en(drv_en), .line_driver_dominant(drv_dom),
    .line_driver_hv(drv_hv), .line_driver_shaped(drv_shaped),
    .line_receiver_en(rcv_en), .load_switch_on(load_on), .irq(irq));

  host_model u_host_model (.pclk(pclk), .regulator_enable_out(reg_en),
    .want_mode(want), .boot_cycles(boot), .mode_select_lo(mlo),
    .mode_select_hi(mhi));

  // 25 MHz clock; a stuck run is cut off by the cycle ceiling.
  always #20 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      close_out();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request stands until ready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Full status compare.
  task automatic st(input logic [31:0] e);
    apb(1'b0, `WCTL_OFS_STATUS, 32'h0000_0000);
    check(rd, e);
  endtask

  // Pending bits, then the level output.
  task automatic irq_chk();
    apb(1'b0, `WCTL_OFS_IRQ, 32'h0000_0000);
    check(rd, m_irq);
    check(irq, (m_irq & m_mask) != 0);
  endtask

  task automatic wait_en(input logic v, input int lim);
    cnt = 0;
    while (reg_en !== v && cnt < lim)
    begin
      cnt++;
      @(posedge pclk);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'h0000_a046));
    tick(2);
    check({drv_shaped, load_on, reg_en}, 3'b110);
    tick(1);
    presetn <= 1'b1;
    tick(8);
    st(32'h0000_0000);
    apb(1'b1, `WCTL_OFS_STATUS, 32'hFFFF_FFFF);
    st(32'h0000_0000);
    apb(1'b0, `WCTL_OFS_HOLD, 32'h0000_0000);
    check(rd, HOLD);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check(er, 1'b1);
    check(rd, 32'h0000_0000);
    apb(1'b1, `WCTL_OFS_MASK, 32'h0000_000F);
    m_mask = 15;
    irq_chk();
    $display("reset and registers done");
    // A wake shorter than the filter is ignored.
    hvw <= 1'b1;
    tick((`WCTL_WAKE_FILT_TICKS - 3) * DIV);
    hvw <= 1'b0;
    tick(100);
    check(reg_en, 1'b0);
    boot <= 8'($urandom_range(40, 2));
    hvw <= 1'b1;
    wait_en(1'b1, 700);
    check(reg_en, 1'b1);
    m_irq = 1;
    tick(20);
    hvw <= 1'b0;
    tick((HOLD + 3) * DIV);
    check(reg_en, 1'b1);
    foreach (modes[i])
    begin
      want <= 2'(modes[i]);
      tick(12);
      check(drv_shaped, modes[i] != 2);
      check(drv_hv, modes[i] == 1);
      st(32'h0000_0004 | modes[i]);
    end
    repeat (20)
    begin
      txd <= 1'($urandom_range(1, 0));
      tick(12);
      check({drv_dom, rxd_oe}, {2{!txd}});
    end
    txd <= 1'b0;
    tick(12);
    txd <= 1'b1;
    tick(20);
    check(drv_en, 1'b1);
    tick((`WCTL_TX_HOLD_TICKS + 2) * DIV);
    check(drv_en, 1'b0);
    $display("wake and modes done");
    // Sleep pins after an expired hold drop the enable at once.
    want <= 2'b00;
    wait_en(1'b0, 100);
    check(reg_en, 1'b0);
    m_irq = 3;
    irq_chk();
    apb(1'b1, `WCTL_OFS_MASK, 32'h0000_0001);
    m_mask = 1;
    apb(1'b1, `WCTL_OFS_IRQ, 32'h0000_0003);
    m_irq = 0;
    irq_chk();
    // The host stays in sleep, so the hold alone keeps the enable up.
    hvw <= 1'b1;
    wait_en(1'b1, 700);
    hvw <= 1'b0;
    wait_en(1'b0, 3000);
    check(cnt >= (HOLD - 1) * DIV && cnt <= (HOLD + 1) * DIV + 20, 1);
    m_irq = 3;
    irq_chk();
    apb(1'b1, `WCTL_OFS_IRQ, 32'h0000_0001);
    m_irq = 2;
    irq_chk();
    $display("hold and interrupt mask done");
    txd <= 1'b0;
    uv <= 1'b1;
    gnd <= 1'b1;
    tick(12);
    check({drv_en, rcv_en, rxd_oe}, 3'b000);
    check(load_on, 1'b0);
    st(32'h0000_0030);
    apb(1'b1, `WCTL_OFS_MASK, 32'h0000_000F);
    m_mask = 15;
    m_irq = 14;
    irq_chk();
    uv <= 1'b0;
    gnd <= 1'b0;
    txd <= 1'b1;
    tick(12);
    check(load_on, 1'b1);
    $display("undervoltage and ground done");
    close_out();
  end
endmodule // sleep_wake_regulator_control_tb_top

`default_nettype wire
